// ==== flc_pkg.sv ====
// Shared constants and types for the flash LED control block
package flc_pkg;
  // ************************************************************
  // Timing
  // ************************************************************
  localparam int unsigned CLK_MHZ       = 125;    // System clock rate
  localparam int unsigned T_START_US    = 500;    // Serial logic startup
  localparam int unsigned T_RAMP_US     = 1400;   // Current ramp-up time
  localparam int unsigned T_SAMPLE_US   = 2000;   // Sample delay after ramp
  localparam int unsigned START_CYC_DEF = T_START_US * CLK_MHZ;
  localparam int unsigned RAMP_CYC_DEF  = T_RAMP_US * CLK_MHZ;
  localparam int unsigned SAMP_CYC_DEF  = T_SAMPLE_US * CLK_MHZ;
  // ************************************************************
  // Serial target address and register offsets
  // ************************************************************
  localparam logic [6:0] DEV_ADDR     = 7'h30;   // 0110000
  localparam logic [7:0] OFS_FLASH    = 8'h01;   // Flash current code
  localparam logic [7:0] OFS_ASSIST   = 8'h02;   // Assist level select
  localparam logic [7:0] OFS_PINCFG   = 8'h03;   // Pin permissions
  localparam logic [7:0] OFS_EVENT    = 8'h07;   // Event mode
  localparam logic [7:0] OFS_MEASURE  = 8'h09;   // measure_control
  localparam logic [7:0] OFS_VIN_RES  = 8'h0a;   // input_voltage_result
  localparam logic [7:0] OFS_VLED_RES = 8'h0b;   // led_voltage_result
  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int BIT_VIN_EN   = 0;               // input_volt_measure_en
  localparam int BIT_VLED_EN  = 1;               // led_volt_measure_en
  localparam int BIT_LATE_SEL = 2;               // sample_after_ramp_sel
  localparam int BIT_TORCH    = 0;               // Torch pin allowed
  localparam int BIT_STRB     = 1;               // Strobe pin allowed
  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [3:0] FLASH_RST   = 4'h9;     // 480+9*30 = 750 mA
  localparam logic       ASSIST_RST  = 1'b0;     // 60 mA
  localparam logic [1:0] PINCFG_RST  = 2'h1;     // Torch yes, strobe no
  localparam logic [1:0] EVENT_RST   = 2'h0;     // No event
  localparam logic [2:0] MEASURE_RST = 3'h0;     // Measurements off
  localparam logic [7:0] RESULT_RST  = 8'h00;    // Empty result
  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {FLC_OFF, FLC_ASSIST, FLC_FLASH} flc_mode_t;
  typedef struct packed {
    logic enable;                                // Standby when high
    logic torch;                                 // Continuous light request
    logic strobe;                                // Flash trigger, level
    logic scl;                                   // Serial clock
    logic sda;                                   // Serial data in
  } flc_pins_t;
  // Pins at rest: bus lines released high, controls low
  localparam flc_pins_t PINS_RST = 5'h03;
endpackage : flc_pkg

// ==== flc_top.sv ====
// Flash LED control: serial target, mode control, converter readout
//
// Functional notes
// - Flash current 480..930 mA, 30 mA steps, 750 default
// - Assist current 60 or 90 mA, 60 default
// - 8-bit converter measures supply and LED voltage
// - Input voltage result when its enable set
// - Sample timing select: before event, or 2ms after ramp done
// - LED voltage result when its enable set
// - LED voltage sampled 2ms after ramp done
// - Enable low shutdown, enable high standby
// - Shutdown blocks control except continuous-light pin
// - Standby accepts serial and permitted pin control
// - Target address 0110000, ack every byte
`timescale 1ns/1ps
module flc_top #(
  parameter int unsigned START_CYC = flc_pkg::START_CYC_DEF, // Startup
  parameter int unsigned RAMP_CYC  = flc_pkg::RAMP_CYC_DEF,  // Ramp time
  parameter int unsigned SAMP_CYC  = flc_pkg::SAMP_CYC_DEF   // Sample wait
) (
  input  wire logic              clk,          // 125 MHz clock
  input  wire logic              reset,        // Async reset, high
  input  wire flc_pkg::flc_pins_t pins,        // Raw control pins
  input  wire logic [7:0]        adc_vin,      // Converter: supply code
  input  wire logic [7:0]        adc_vled,     // Converter: LED code
  output logic                   sda_o,        // Data pin drive level
  output logic                   sda_oe,       // Data pin enable, high
  output flc_pkg::flc_mode_t     led_mode,     // Current source mode
  output logic [3:0]             flash_code,   // Flash current code
  output logic                   assist_hi,    // Assist 90 mA when high
  output logic                   standby,      // Standby state
  output logic [7:0]             vin_result,   // Supply result
  output logic [7:0]             vled_result   // LED voltage result
);
  import flc_pkg::*;

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  flc_pins_t s1_q, s2_q, s3_q;                  // Three-stage sync
  flc_pins_t f_q;                               // Accepted pin levels
  flc_pins_t f_d;                               // Next accepted levels
  // Accept a level only once stages two and three agree
  assign f_d = (s2_q & ~(s2_q ^ s3_q)) | (f_q & (s2_q ^ s3_q));

  // Chain runs every cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      // Idle bus levels, so no false edge follows reset
      s1_q <= PINS_RST;
      s2_q <= PINS_RST;
      s3_q <= PINS_RST;
      f_q  <= PINS_RST;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
      f_q  <= f_d;
    end
  end

  logic scl_p_q, sda_p_q;                        // Previous bus levels
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= f_q.scl;
      sda_p_q <= f_q.sda;
    end
  end
  wire scl_rise = f_q.scl & ~scl_p_q;            // Clock rising edge
  wire scl_fall = ~f_q.scl & scl_p_q;            // Clock falling edge
  wire bus_start = f_q.scl & scl_p_q & sda_p_q & ~f_q.sda;
  wire bus_stop  = f_q.scl & scl_p_q & ~sda_p_q & f_q.sda;

  // ************************************************************
  // Standby and startup timer
  // ************************************************************
  // enable level selects mode
  wire stby = f_q.enable;
  logic [15:0] st_cnt_q;                         // Startup counter
  logic        ready_q;                          // Serial logic awake
  // serial logic ignores the bus while waking
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_cnt_q <= '0;
      ready_q  <= 1'b0;
    end else if (!stby) begin
      st_cnt_q <= '0;
      ready_q  <= 1'b0;
    end else if (!ready_q) begin
      st_cnt_q <= st_cnt_q + 16'h0001;
      ready_q  <= (st_cnt_q == 16'(START_CYC - 1));
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  logic [3:0] flash_q;                           // Flash current code
  logic       assist_q;                          // Assist level
  logic [1:0] pincfg_q;                          // Pin permissions
  logic [1:0] event_q;                           // Serial event mode
  logic [2:0] meas_q;                            // measure_control
  logic [7:0] vin_q, vled_q;                     // Results
  logic       wr_q;                              // Write strobe
  logic [7:0] ptr_q, wdat_q;                     // Write address, data

  // Read mux, used for every transmitted byte
  function automatic logic [7:0] reg_read(input logic [7:0] a,
      input logic [3:0] fl, input logic as, input logic [1:0] pc,
      input logic [1:0] ev, input logic [2:0] ms, input logic [7:0] vi,
      input logic [7:0] vl);
    unique case (a)
      OFS_FLASH:    reg_read = {4'h0, fl};
      OFS_ASSIST:   reg_read = {7'h00, as};
      OFS_PINCFG:   reg_read = {6'h00, pc};
      OFS_EVENT:    reg_read = {6'h00, ev};
      OFS_MEASURE:  reg_read = {5'h00, ms};
      OFS_VIN_RES:  reg_read = vi;
      OFS_VLED_RES: reg_read = vl;
      default:      reg_read = 8'h00;            // Unmapped reads zero
    endcase
  endfunction : reg_read

  // shutdown reloads defaults; writes only in standby
  // flash code 0..15 spans 480..930 mA
  // one bit picks 60 or 90 mA
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      flash_q  <= FLASH_RST;
      assist_q <= ASSIST_RST;
      pincfg_q <= PINCFG_RST;
      event_q  <= EVENT_RST;
      meas_q   <= MEASURE_RST;
    end else if (!stby) begin
      // Shutdown reload kept apart from the async reset branch
      flash_q  <= FLASH_RST;
      assist_q <= ASSIST_RST;
      pincfg_q <= PINCFG_RST;
      event_q  <= EVENT_RST;
      meas_q   <= MEASURE_RST;
    end else if (wr_q) begin
      if (ptr_q == OFS_FLASH)   flash_q  <= wdat_q[3:0];
      if (ptr_q == OFS_ASSIST)  assist_q <= wdat_q[0];
      if (ptr_q == OFS_PINCFG)  pincfg_q <= wdat_q[1:0];
      if (ptr_q == OFS_EVENT)   event_q  <= wdat_q[1:0];
      if (ptr_q == OFS_MEASURE) meas_q   <= wdat_q[2:0];
    end
  end

  // ************************************************************
  // Serial target
  // ************************************************************
  typedef enum logic [2:0] {I_IDLE, I_ADDR, I_REG, I_DATA, I_ACK, I_TX,
                            I_RACK} flc_i2c_t;
  flc_i2c_t   ist_q, inxt_q;                     // State, after-ack state
  logic [7:0] sh_q;                              // Receive shift
  logic [7:0] tx_q;                              // Transmit shift
  logic [3:0] bc_q;                              // Bit count
  logic       oe_q;                              // Data pin enable
  wire  rx_st = (ist_q == I_ADDR) || (ist_q == I_REG) || (ist_q == I_DATA);
  wire  [7:0] rd_byte = reg_read(ptr_q, flash_q, assist_q, pincfg_q,
                                 event_q, meas_q, vin_q, vled_q);

  // Bus protocol walker; start and stop override all states
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ist_q  <= I_IDLE;
      inxt_q <= I_IDLE;
      sh_q   <= '0;
      tx_q   <= '0;
      bc_q   <= '0;
      oe_q   <= 1'b0;
      wr_q   <= 1'b0;
      ptr_q  <= '0;
      wdat_q <= '0;
    end else begin
      wr_q <= 1'b0;
      if (!stby || !ready_q || bus_stop) begin
        ist_q <= I_IDLE;
        oe_q  <= 1'b0;
      end else if (bus_start) begin
        ist_q <= I_ADDR;
        bc_q  <= '0;
        oe_q  <= 1'b0;
      end else if (rx_st && scl_rise && bc_q != 4'h8) begin
        sh_q <= {sh_q[6:0], f_q.sda};
        bc_q <= bc_q + 4'h1;
      end else if (rx_st && scl_fall && bc_q == 4'h8) begin
        bc_q <= '0;
        // ack own address and every following byte
        if (ist_q == I_ADDR) begin
          oe_q   <= (sh_q[7:1] == DEV_ADDR);
          ist_q  <= (sh_q[7:1] == DEV_ADDR) ? I_ACK : I_IDLE;
          inxt_q <= sh_q[0] ? I_TX : I_REG;
        end else if (ist_q == I_REG) begin
          ptr_q  <= sh_q;
          oe_q   <= 1'b1;
          ist_q  <= I_ACK;
          inxt_q <= I_DATA;
        end else begin
          // third byte writes the selected register
          wdat_q <= sh_q;
          wr_q   <= 1'b1;
          oe_q   <= 1'b1;
          ist_q  <= I_ACK;
          inxt_q <= I_DATA;
        end
      end else if (ist_q == I_ACK && scl_fall) begin
        ist_q <= inxt_q;
        tx_q  <= rd_byte;
        oe_q  <= (inxt_q == I_TX) && !rd_byte[7];
      end else if (ist_q == I_TX && scl_fall) begin
        bc_q  <= bc_q + 4'h1;
        tx_q  <= {tx_q[6:0], 1'b0};
        oe_q  <= (bc_q != 4'h7) && !tx_q[6];
        ist_q <= (bc_q == 4'h7) ? I_RACK : I_TX;
      end else if (ist_q == I_RACK && scl_rise) begin
        bc_q   <= '0;
        ist_q  <= f_q.sda ? I_IDLE : I_ACK;
        inxt_q <= I_TX;
      end
    end
  end

  // ************************************************************
  // Event control and converter sampling
  // ************************************************************
  typedef enum logic [1:0] {E_OFF, E_RAMP, E_SETTLE, E_ON} flc_ev_t;
  flc_ev_t    ev_q;                              // Event state
  logic [19:0] ec_q;                             // Event timer
  // in shutdown only the torch pin starts light
  // standby: serial mode or permitted pins
  wire pin_torch = f_q.torch & (~stby | pincfg_q[BIT_TORCH]);
  wire pin_flash = stby & f_q.strobe & pincfg_q[BIT_STRB];
  wire want_fl   = (stby & (event_q == 2'h2)) | pin_flash;
  wire want_as   = (stby & (event_q == 2'h1)) | pin_torch;
  wire want      = want_fl | want_as;
  wire ramp_end  = (ev_q == E_RAMP) && (ec_q == 20'(RAMP_CYC - 1));
  wire samp_now  = (ev_q == E_SETTLE) && (ec_q == 20'(SAMP_CYC - 1));

  // Event sequencer; dropping the request ends the event at once
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ev_q <= E_OFF;
      ec_q <= '0;
    end else if (!want) begin
      ev_q <= E_OFF;
      ec_q <= '0;
    end else begin
      ec_q <= (ramp_end || samp_now) ? 20'h0_0000 : ec_q + 20'h0_0001;
      unique case (ev_q)
        E_OFF: begin
          ev_q <= E_RAMP;
          ec_q <= '0;
        end
        E_RAMP:   if (ramp_end) ev_q <= E_SETTLE;
        E_SETTLE: if (samp_now) ev_q <= E_ON;
        E_ON:     ec_q <= '0;
      endcase
    end
  end

  // select bit picks event start or settle end
  wire samp_early = (ev_q == E_OFF) && want && !meas_q[BIT_LATE_SEL];
  wire samp_late  = samp_now && meas_q[BIT_LATE_SEL];

  // both 8-bit codes captured from the converter
  // results keep value until a new enabled sample
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      vin_q  <= RESULT_RST;
      vled_q <= RESULT_RST;
    end else begin
      // supply sample before or after ramp
      if (meas_q[BIT_VIN_EN] && (samp_early || samp_late))
        vin_q <= adc_vin;
      if (meas_q[BIT_VLED_EN] && samp_now)
        vled_q <= adc_vled;
    end
  end

  // ************************************************************
  // Registered outputs
  // ************************************************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sda_o       <= 1'b0;
      sda_oe      <= 1'b0;
      led_mode    <= FLC_OFF;
      flash_code  <= FLASH_RST;
      assist_hi   <= ASSIST_RST;
      standby     <= 1'b0;
      vin_result  <= RESULT_RST;
      vled_result <= RESULT_RST;
    end else begin
      sda_o       <= 1'b0;
      sda_oe      <= oe_q;
      led_mode    <= !want ? FLC_OFF : (want_fl ? FLC_FLASH : FLC_ASSIST);
      flash_code  <= flash_q;
      // Shutdown torch always runs at the low assist level
      assist_hi   <= stby & assist_q;
      standby     <= stby;
      vin_result  <= vin_q;
      vled_result <= vled_q;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  // shutdown defaults
  shut_dflt_a: assert property (@(posedge clk)
    disable iff (reset)
    !stby |=> flash_q == FLASH_RST && meas_q == MEASURE_RST)
    else $error("defaults not restored in shutdown");
  wake_quiet_a: assert property (@(posedge clk)
    disable iff (reset) !ready_q |=> !oe_q)
    else $error("bus driven before startup");
  addr_ack_a: assert property (@(posedge clk)
    disable iff (reset)
    ist_q == I_ADDR && scl_fall && bc_q == 4'h8 && sh_q[7:1] != DEV_ADDR
    |=> ist_q == I_IDLE && !oe_q) else $error("foreign address acked");
  // data byte writes the selected register
  wr_data_a: assert property (@(posedge clk)
    disable iff (reset)
    wr_q && stby && ptr_q == OFS_FLASH |=> flash_q == $past(wdat_q[3:0]))
    else $error("flash write lost");
  // LED sample taken at the settle end
  led_samp_a: assert property (@(posedge clk)
    disable iff (reset)
    samp_now && meas_q[BIT_VLED_EN] |=> vled_q == $past(adc_vled))
    else $error("LED sample missed");
  res_hold_a: assert property (@(posedge clk)
    disable iff (reset) !samp_now |=> $stable(vled_q))
    else $error("LED result changed");
  // early supply sample only with select low
  vin_early_a: assert property (@(posedge clk)
    disable iff (reset)
    ev_q == E_OFF && want && meas_q[BIT_VIN_EN] && !meas_q[BIT_LATE_SEL]
    |=> vin_q == $past(adc_vin)) else $error("early supply sample missed");
  // shutdown light only from torch pin
  shut_torch_a: assert property (@(posedge clk)
    disable iff (reset) !stby && !f_q.torch |=> led_mode == FLC_OFF)
    else $error("light in shutdown without torch");
  ramp_seq_a: assert property (@(posedge clk)
    disable iff (reset) ev_q == E_OFF && want |=> ev_q == E_RAMP)
    else $error("ramp skipped");
  cov_write_c: cover property (@(posedge clk) disable iff (reset) wr_q);
  cov_read_c:  cover property (@(posedge clk) disable iff (reset)
    ist_q == I_TX);
  cov_samp_c:  cover property (@(posedge clk) disable iff (reset)
    samp_now && meas_q[BIT_VLED_EN]);
endmodule : flc_top

// ==== flc_host.sv ====
// Serial host model that drives the flash control target
`timescale 1ns/1ps
module flc_host (
  input  wire logic clk,     // Bench clock
  input  wire logic sda_oe,  // Target pulls data low
  output logic      scl,     // Serial clock, idles high
  output wire logic sda      // Resolved data wire
);
  import flc_pkg::*;
  logic sda_drv;             // Host level, high = released
  // Pull-up wins unless a party pulls low
  assign sda = sda_drv & ~sda_oe;
  initial begin
    scl     = 1'b1;
    sda_drv = 1'b1;
  end
  // ****************************************************
  // Bus cycle tasks
  // ****************************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // Data moves only while clock low; read mid-high
  task automatic bit_io(input logic b, output logic r);
    cyc(8);
    sda_drv <= b;
    cyc(8);
    scl <= 1'b1;
    cyc(8);
    @(negedge clk);
    r = sda;
    cyc(8);
    scl <= 1'b0;
  endtask : bit_io
  // MSB first, then one ack slot
  task automatic byte_io(input logic [7:0] tx, input logic ak_in,
                         output logic [7:0] rx, output logic ak);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], r);
      rx[i] = r;
    end
    bit_io(ak_in, ak);
  endtask : byte_io
  // Also serves as repeated start
  task automatic start();
    cyc(8);
    sda_drv <= 1'b1;
    cyc(8);
    scl <= 1'b1;
    cyc(16);
    sda_drv <= 1'b0;
    cyc(16);
    scl <= 1'b0;
  endtask : start
  task automatic stop();
    cyc(8);
    sda_drv <= 1'b0;
    cyc(8);
    scl <= 1'b1;
    cyc(16);
    sda_drv <= 1'b1;
    cyc(16);
  endtask : stop
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ofs,
                           input logic [7:0] dat, output logic [2:0] aks);
    logic [7:0] rx;
    start();
    byte_io({dev, 1'b0}, 1'b1, rx, aks[2]);
    byte_io(ofs, 1'b1, rx, aks[1]);
    byte_io(dat, 1'b1, rx, aks[0]);
    stop();
  endtask : write_reg
  // Pointer write, repeated start, one byte then no-ack
  task automatic read_reg(input logic [7:0] ofs, output logic [7:0] dat,
                          output logic [2:0] aks);
    logic nk;
    start();
    byte_io({DEV_ADDR, 1'b0}, 1'b1, dat, aks[2]);
    byte_io(ofs, 1'b1, dat, aks[1]);
    start();
    byte_io({DEV_ADDR, 1'b1}, 1'b1, dat, aks[0]);
    byte_io(8'hff, 1'b1, dat, nk);
    stop();
  endtask : read_reg
endmodule : flc_host

// ==== tb.sv ====
// Self-checking bench for the flash control block
`timescale 1ns/1ps
module tb;
  import flc_pkg::*;
  localparam int unsigned ST = 200;   // Short startup window
  localparam int unsigned RP = 1000;  // Short ramp
  localparam int unsigned SP = 1000;  // Short settle
  logic       clk, reset;             // Clock, async reset
  logic       en, torch, strobe;      // Control pins
  logic [7:0] adc_vin, adc_vled;      // Converter codes
  logic       scl, sda, sda_o, sda_oe; // Serial wires
  flc_mode_t  led_mode;               // Source mode
  logic [3:0] flash_code;             // Flash code
  logic       assist_hi, standby;     // Assist level, state
  logic [7:0] vin_result, vled_result; // Results
  logic [7:0] rdv;                    // Read data
  logic [2:0] acks;                   // Ack bits, low = acked
  int         err_total, checked;     // Counters
  flc_pins_t  pins;                   // Pin bundle
  assign pins = {en, torch, strobe, scl, sda};
  flc_top #(.START_CYC(ST), .RAMP_CYC(RP), .SAMP_CYC(SP)) i_dut (
    .clk(clk), .reset(reset), .pins(pins), .adc_vin(adc_vin),
    .adc_vled(adc_vled), .sda_o(sda_o), .sda_oe(sda_oe),
    .led_mode(led_mode), .flash_code(flash_code), .assist_hi(assist_hi),
    .standby(standby), .vin_result(vin_result), .vled_result(vled_result));
  flc_host i_host (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ****************************************************
  // Helpers
  // ****************************************************
  task automatic cmp(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask : cmp
  task automatic stop_test();
    $display("compares %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done
  // Bounded wait; a timeout ends the run
  task automatic wait_mode(input flc_mode_t m);
    for (int k = 0; k < 60 && led_mode !== m; k++) begin
      @(posedge clk);
    end
    cmp(8'(led_mode), 8'(m));
    if (led_mode !== m) begin
      stop_test();
    end
  endtask : wait_mode
  task automatic wr(input logic [6:0] d, input logic [7:0] o,
                    input logic [7:0] v, input logic [2:0] ea);
    i_host.write_reg(d, o, v, acks);
    cmp({5'h0, acks}, {5'h0, ea});
  endtask : wr
  task automatic rd(input logic [7:0] o, input logic [7:0] ev);
    i_host.read_reg(o, rdv, acks);
    cmp({5'h0, acks}, 8'h00);
    cmp(rdv, ev);
  endtask : rd
  // ****************************************************
  // Main sequence
  // ****************************************************
  initial begin
    err_total = 0;
    checked   = 0;
    reset     = 1'b1;
    en        = 1'b0;  // Low until supply is up
    torch     = 1'b0;
    strobe    = 1'b0;
    adc_vin   = 8'ha1;
    adc_vled  = 8'hb2;
    cyc(8);
    reset <= 1'b0;
    cyc(2);
    cmp({4'h0, flash_code}, {4'h0, FLASH_RST});
    cmp({7'h0, assist_hi}, 8'h00);
    cmp({7'h0, standby}, 8'h00);
    wr(DEV_ADDR, OFS_EVENT, 8'h01, 3'b111);
    torch <= 1'b1;
    wait_mode(FLC_ASSIST);
    cmp({7'h0, assist_hi}, 8'h00);
    torch <= 1'b0;
    wait_mode(FLC_OFF);
    done("shutdown");
    en <= 1'b1;
    cyc(6);
    cmp({7'h0, standby}, 8'h01);
    wr(DEV_ADDR, OFS_FLASH, 8'h0f, 3'b111);
    cmp({4'h0, flash_code}, {4'h0, FLASH_RST});
    cyc(ST);
    wr(7'h31, OFS_FLASH, 8'h0f, 3'b111);
    done("startup");
    // Code 0 is 480 mA, code 15 is 930 mA
    for (int c = 0; c < 16; c++) begin
      wr(DEV_ADDR, OFS_FLASH, 8'(c), 3'b000);
      cmp({4'h0, flash_code}, 8'(c));
      rd(OFS_FLASH, 8'(c));
    end
    wr(DEV_ADDR, OFS_ASSIST, 8'h01, 3'b000);
    cmp({7'h0, assist_hi}, 8'h01);
    cmp({7'h0, sda_o}, 8'h00);
    cmp({7'h0, sda_oe}, 8'h00);
    done("currents");
    wr(DEV_ADDR, OFS_MEASURE, 8'h03, 3'b000);
    wr(DEV_ADDR, OFS_EVENT, 8'h01, 3'b000);
    wait_mode(FLC_ASSIST);
    adc_vin <= 8'h55;
    cyc(1700);
    cmp(vled_result, RESULT_RST);
    cyc(400);
    cmp(vled_result, 8'hb2);
    cmp(vin_result, 8'ha1);
    rd(OFS_VIN_RES, 8'ha1);
    rd(OFS_VLED_RES, 8'hb2);
    wr(DEV_ADDR, OFS_EVENT, 8'h00, 3'b000);
    wait_mode(FLC_OFF);
    done("sample early");
    wr(DEV_ADDR, OFS_MEASURE, 8'h05, 3'b000);
    adc_vled <= 8'h3c;
    wr(DEV_ADDR, OFS_EVENT, 8'h02, 3'b000);
    wait_mode(FLC_FLASH);
    adc_vin <= 8'hc3;
    cyc(1700);
    cmp(vin_result, 8'ha1);
    cyc(400);
    cmp(vin_result, 8'hc3);
    cmp(vled_result, 8'hb2);
    wr(DEV_ADDR, OFS_EVENT, 8'h00, 3'b000);
    wr(DEV_ADDR, OFS_VIN_RES, 8'hff, 3'b000);
    rd(OFS_VIN_RES, 8'hc3);
    rd(8'h0e, 8'h00);
    done("sample late");
    // Strobe needs its permission bit
    strobe <= 1'b1;
    cyc(20);
    cmp(8'(led_mode), 8'(FLC_OFF));
    wr(DEV_ADDR, OFS_PINCFG, 8'h03, 3'b000);
    wait_mode(FLC_FLASH);
    strobe <= 1'b0;
    wait_mode(FLC_OFF);
    done("strobe");
    en <= 1'b0;
    cyc(8);
    cmp({4'h0, flash_code}, {4'h0, FLASH_RST});
    cmp({7'h0, assist_hi}, 8'h00);
    cmp({7'h0, standby}, 8'h00);
    cmp(vin_result, 8'hc3);
    en <= 1'b1;
    cyc(ST + 20);
    rd(OFS_MEASURE, 8'h00);
    done("re-shutdown");
    stop_test();
  end
endmodule : tb
